// [rtcsp_pkg.sv]
// shared constants and types for the rtc serial slave port and its master
package rtcsp_pkg;

	// ==========================================================
	// data path widths
	localparam int unsigned ADDR_W   = 6;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned CNT_W    = 7;
	localparam int unsigned TMR_W    = 4;
	localparam int unsigned RCNT_W   = 24;

	// ==========================================================
	// address map and bit positions
	localparam logic [ADDR_W-1:0] ADDR_ZERO   = 6'h00;
	localparam logic [ADDR_W-1:0] CLOCK_TOP   = 6'h08; // first address past the clock bytes
	localparam logic [ADDR_W-1:0] ADDR_STEP   = 6'h01;
	localparam logic [2:0]        BIT_FIRST   = 3'h0;
	localparam logic [2:0]        BIT_LAST    = 3'h7;
	localparam logic [2:0]        BIT_STEP    = 3'h1;
	localparam logic [CNT_W-1:0]  LEFT_NONE   = 7'h00;
	localparam logic [CNT_W-1:0]  LEFT_STEP   = 7'h01;
	localparam logic [DATA_W-1:0] BYTE_ZERO   = 8'h00;
	localparam logic              DIR_WRITE   = 1'b1;

	// ==========================================================
	// timing: figures in ns, counts derived at the 20 MHz system clock
	localparam int unsigned CLK_PERIOD_NS            = 50;
	localparam int unsigned SCLK_HALF_NS             = 250; // 2 MHz serial clock at most
	localparam int unsigned SEL_LEAD_NS              = 200; // select low to first clock rise
	localparam int unsigned SEL_LAG_NS               = 200; // last clock to select high
	localparam int unsigned DESELECT_RECOVERY_TIME_NS = 200; // select high between frames
	localparam logic [TMR_W-1:0] SCLK_HALF_CYC =
		TMR_W'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] SEL_LEAD_CYC =
		TMR_W'((SEL_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] SEL_LAG_CYC =
		TMR_W'((SEL_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] DESELECT_RECOVERY_CYC =
		TMR_W'((DESELECT_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
	localparam logic [TMR_W-1:0] TMR_STEP = 4'h1;

	// recovery_hold_time: plain default of 1 ms, override per system
	localparam logic [RCNT_W-1:0] RECOVERY_HOLD_CYC_DEFAULT = 24'h004E20;
	localparam logic [RCNT_W-1:0] RCNT_ZERO = 24'h000000;
	localparam logic [RCNT_W-1:0] RCNT_STEP = 24'h000001;

	// ==========================================================
	// state encodings, one-hot
	typedef enum logic [5:0] {
		DEV_ARM     = 6'h01,
		DEV_IDLE    = 6'h02,
		DEV_CMD     = 6'h04,
		DEV_DATA    = 6'h08,
		DEV_FAIL    = 6'h10,
		DEV_RECOVER = 6'h20
	} rtcsp_dev_state_e;

	typedef enum logic [4:0] {
		MST_GAP   = 5'h01,
		MST_IDLE  = 5'h02,
		MST_LEAD  = 5'h04,
		MST_SHIFT = 5'h08,
		MST_LAG   = 5'h10
	} rtcsp_mst_state_e;

endpackage

// [rtcsp_if.sv]
// serial pins between the rtc port and its microcontroller master
interface rtcsp_if;
	logic sclk;
	logic sel_n;
	logic mosi;
	logic miso_drv;
	logic miso_oe;
	logic miso;
	logic rst_n_drv;
	logic rst_n_oe;
	logic rst_n;

	// ==========================================================
	// wire resolution: pulled-up lines, driven only while enabled
	assign miso  = miso_oe ? miso_drv : 1'b1;
	assign rst_n = rst_n_oe ? rst_n_drv : 1'b1;

	modport dev (
		input  sclk,
		input  sel_n,
		input  mosi,
		output miso_drv,
		output miso_oe,
		output rst_n_drv,
		output rst_n_oe
	);

	modport host (
		output sclk,
		output sel_n,
		output mosi,
		input  miso,
		input  rst_n
	);
endinterface

// [rtcsp_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
module rtcsp_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	input  wire logic         ce_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} rtcsp_sync_s;

	rtcsp_sync_s q, d;

	// ==========================================================
	// first stage feeds only the second stage
	always_comb begin
		d      = q;
		d.meta = d_in;
		d.sync = q.meta;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q <= '0;
		end else if (ce_in) begin
			q <= d;
		end
	end

	assign q_out = q.sync;
endmodule

// [rtcsp_device.sv]
// device end of the rtc serial slave port: command decode, pointer and power-fail lockout
module rtcsp_device #(
	parameter logic [rtcsp_pkg::RCNT_W-1:0] RECOVERY_HOLD_CYC =
		rtcsp_pkg::RECOVERY_HOLD_CYC_DEFAULT
) (
	input  wire logic                            clk_in,
	input  wire logic                            srst_in,
	input  wire logic                            ce_in,
	rtcsp_if.dev                                 bus,
	input  wire logic                            power_fail_trip_in,
	input  wire logic                            battery_switch_level_in,
	input  wire logic [rtcsp_pkg::DATA_W-1:0]    mem_rdata_in,
	output logic      [rtcsp_pkg::ADDR_W-1:0]    mem_addr_out,
	output logic      [rtcsp_pkg::DATA_W-1:0]    mem_wdata_out,
	output logic                                 mem_we_out,
	output logic                                 clock_hold_out,
	output logic                                 divider_reset_out,
	output logic                                 reset_active_out
);

	// ==========================================================
	// state record
	typedef struct packed {
		rtcsp_pkg::rtcsp_dev_state_e     state;
		logic                            sclk_prev;
		logic                            sel_prev;
		logic [rtcsp_pkg::DATA_W-1:0]    rx;
		logic [rtcsp_pkg::DATA_W-1:0]    tx;
		logic [2:0]                      bitcnt;
		logic [rtcsp_pkg::ADDR_W-1:0]    ptr;
		logic                            wr;
		logic                            miso;
		logic                            miso_oe;
		logic                            rst_n_drv;
		logic                            rst_n_oe;
		logic                            rst_act;
		logic [rtcsp_pkg::ADDR_W-1:0]    mem_addr;
		logic [rtcsp_pkg::DATA_W-1:0]    wdata;
		logic                            mem_we;
		logic                            div_rst;
		logic                            hold;
		logic [rtcsp_pkg::RCNT_W-1:0]    rcnt;
	} rtcsp_dev_s;

	rtcsp_dev_s q, d;

	logic [4:0] pins_s;
	logic       sclk_s;
	logic       sel_n_s;
	logic       mosi_s;
	logic       pf_s;
	logic       bat_s;
	logic       rise;
	logic       fall;
	logic [rtcsp_pkg::DATA_W-1:0] rx_next;

	// ==========================================================
	// pin and supply-monitor synchronisation
	// serial pins come from another chip, so edges are found on the synced copies
	rtcsp_sync #(
		.W (5)
	) u_sync (
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.ce_in   (ce_in),
		.d_in    ({bus.sclk, bus.sel_n, bus.mosi, power_fail_trip_in,
		           battery_switch_level_in}),
		.q_out   (pins_s)
	);

	assign {sclk_s, sel_n_s, mosi_s, pf_s, bat_s} = pins_s;

	// edges compared against the last synced level, never the first stage
	assign rise    = sclk_s & ~q.sclk_prev;
	assign fall    = ~sclk_s & q.sclk_prev;
	assign rx_next = {q.rx[rtcsp_pkg::DATA_W-2:0], mosi_s};

	// ==========================================================
	// next-state logic
	always_comb begin
		d           = q;
		d.sclk_prev = sclk_s;
		d.sel_prev  = sel_n_s;
		d.mem_we    = 1'b0;
		d.div_rst   = 1'b0;
		d.rst_n_drv = 1'b0;
		d.mem_addr  = q.ptr;

		case (q.state)
			// after reset a high select must be seen before a falling edge counts
			rtcsp_pkg::DEV_ARM: begin
				if (sel_n_s) begin
					d.state = rtcsp_pkg::DEV_IDLE;
				end
			end
			rtcsp_pkg::DEV_IDLE: begin
				d.bitcnt  = rtcsp_pkg::BIT_FIRST;
				d.miso_oe = 1'b0;
				if (q.sel_prev && !sel_n_s) begin
					d.state = rtcsp_pkg::DEV_CMD;
				end
			end
			// command byte: direction then seven address bits
			rtcsp_pkg::DEV_CMD: begin
				if (rise) begin
					d.rx     = rx_next;
					d.bitcnt = q.bitcnt + rtcsp_pkg::BIT_STEP;
					if (q.bitcnt == rtcsp_pkg::BIT_LAST) begin
						d.wr    = q.rx[rtcsp_pkg::DATA_W-2];
						d.ptr   = rx_next[rtcsp_pkg::ADDR_W-1:0];
						d.state = rtcsp_pkg::DEV_DATA;
					end
				end
			end
			// data bytes in burst until select rises
			rtcsp_pkg::DEV_DATA: begin
				if (rise) begin
					d.rx     = rx_next;
					d.bitcnt = q.bitcnt + rtcsp_pkg::BIT_STEP;
					if (q.bitcnt == rtcsp_pkg::BIT_LAST) begin
						if (q.wr == rtcsp_pkg::DIR_WRITE) begin
							d.mem_we = 1'b1;
							d.wdata  = rx_next;
							d.div_rst = (q.ptr < rtcsp_pkg::CLOCK_TOP);
						end
						// six-bit pointer wraps from the top back to zero
						d.ptr = q.ptr + rtcsp_pkg::ADDR_STEP;
					end
				end
				// read data moves out on falling edges only, one bit per edge, top bit first
				if (fall && q.wr != rtcsp_pkg::DIR_WRITE) begin
					d.miso_oe = 1'b1;
					if (q.bitcnt == rtcsp_pkg::BIT_FIRST) begin
						d.tx   = mem_rdata_in;
						d.miso = mem_rdata_in[rtcsp_pkg::DATA_W-1];
					end else begin
						d.tx   = {q.tx[rtcsp_pkg::DATA_W-2:0], 1'b0};
						d.miso = q.tx[rtcsp_pkg::DATA_W-2];
					end
				end
			end
			rtcsp_pkg::DEV_FAIL: begin
				if (!pf_s) begin
					d.rcnt  = rtcsp_pkg::RCNT_ZERO;
					d.state = rtcsp_pkg::DEV_RECOVER;
				end
			end
			// select is not looked at until the hold time has run out
			rtcsp_pkg::DEV_RECOVER: begin
				d.rcnt = q.rcnt + rtcsp_pkg::RCNT_STEP;
				if (q.rcnt == RECOVERY_HOLD_CYC - rtcsp_pkg::RCNT_STEP) begin
					d.state = rtcsp_pkg::DEV_ARM;
				end
			end
			default: begin
				d.state = rtcsp_pkg::DEV_ARM;
			end
		endcase

		// deselect ends the frame and floats the output at once
		if (sel_n_s && (q.state == rtcsp_pkg::DEV_CMD || q.state == rtcsp_pkg::DEV_DATA)) begin
			d.state   = rtcsp_pkg::DEV_IDLE;
			d.miso_oe = 1'b0;
		end

		// power fail beats everything: abort, clear pointer, drop the strobe
		if (pf_s) begin
			d.state   = rtcsp_pkg::DEV_FAIL;
			d.ptr     = rtcsp_pkg::ADDR_ZERO;
			d.mem_addr = rtcsp_pkg::ADDR_ZERO;
			d.mem_we  = 1'b0;
			d.div_rst = 1'b0;
			d.miso_oe = 1'b0;
			d.bitcnt  = rtcsp_pkg::BIT_FIRST;
		end

		// copies freeze only while the pointer sits on a clock byte mid-frame
		d.hold    = (d.state == rtcsp_pkg::DEV_DATA) && (d.ptr < rtcsp_pkg::CLOCK_TOP);
		d.rst_act = (d.state == rtcsp_pkg::DEV_FAIL) ||
		            (d.state == rtcsp_pkg::DEV_RECOVER);
		d.rst_n_oe = d.rst_act && !bat_s;

		// on battery the pins all float
		if (bat_s) begin
			d.miso_oe  = 1'b0;
			d.rst_n_oe = 1'b0;
		end
	end

	// ==========================================================
	// state register, frozen while the clock enable is low
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q       <= '0;
			q.state <= rtcsp_pkg::DEV_ARM;
		end else if (ce_in) begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs straight from the state record
	assign bus.miso_drv      = q.miso;
	assign bus.miso_oe       = q.miso_oe;
	assign bus.rst_n_drv     = q.rst_n_drv;
	assign bus.rst_n_oe      = q.rst_n_oe;
	assign mem_addr_out      = q.mem_addr;
	assign mem_wdata_out     = q.wdata;
	assign mem_we_out        = q.mem_we;
	assign clock_hold_out    = q.hold;
	assign divider_reset_out = q.div_rst;
	assign reset_active_out  = q.rst_act;
endmodule

// [rtcsp_master.sv]
// microcontroller end: spi mode zero master that frames command and burst bytes
module rtcsp_master (
	input  wire logic                            clk_in,
	input  wire logic                            srst_in,
	input  wire logic                            ce_in,
	rtcsp_if.host                                bus,
	input  wire logic                            start_in,
	input  wire logic                            write_in,
	input  wire logic [rtcsp_pkg::CNT_W-1:0]     addr_in,
	input  wire logic [rtcsp_pkg::CNT_W-1:0]     count_in,
	input  wire logic [rtcsp_pkg::DATA_W-1:0]    wdata_in,
	output logic                                 wdata_take_out,
	output logic      [rtcsp_pkg::DATA_W-1:0]    rdata_out,
	output logic                                 rdata_valid_out,
	output logic                                 busy_out,
	output logic                                 dev_reset_out
);

	// ==========================================================
	// state record
	typedef struct packed {
		rtcsp_pkg::rtcsp_mst_state_e     state;
		logic [rtcsp_pkg::TMR_W-1:0]     tmr;
		logic                            sclk;
		logic                            sel_n;
		logic                            mosi;
		logic [rtcsp_pkg::DATA_W-1:0]    sh;
		logic [rtcsp_pkg::DATA_W-1:0]    rx;
		logic [2:0]                      bitcnt;
		logic [rtcsp_pkg::CNT_W-1:0]     left;
		logic                            first;
		logic                            wr;
		logic                            take;
		logic                            rvalid;
		logic [rtcsp_pkg::DATA_W-1:0]    rdata;
		logic                            busy;
		logic                            dev_rst;
	} rtcsp_mst_s;

	rtcsp_mst_s q, d;
	logic [1:0] in_s;
	logic       miso_s;
	logic       rst_n_s;
	logic [rtcsp_pkg::DATA_W-1:0] rx_next;

	// miso and the reset line are pins, so they are synchronised first
	rtcsp_sync #(
		.W (2)
	) u_sync (
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.ce_in   (ce_in),
		.d_in    ({bus.miso, bus.rst_n}),
		.q_out   (in_s)
	);

	assign {miso_s, rst_n_s} = in_s;
	assign rx_next = {q.rx[rtcsp_pkg::DATA_W-2:0], miso_s};

	// ==========================================================
	// next-state logic
	always_comb begin
		d         = q;
		d.take    = 1'b0;
		d.rvalid  = 1'b0;
		d.dev_rst = !rst_n_s;

		case (q.state)
			// select held high for the recovery gap before every frame
			rtcsp_pkg::MST_GAP: begin
				d.sel_n = 1'b1;
				d.tmr   = q.tmr + rtcsp_pkg::TMR_STEP;
				if (q.tmr == rtcsp_pkg::DESELECT_RECOVERY_CYC - rtcsp_pkg::TMR_STEP) begin
					d.state = rtcsp_pkg::MST_IDLE;
				end
			end
			rtcsp_pkg::MST_IDLE: begin
				if (start_in) begin
					d.wr     = write_in;
					d.left   = count_in;
					d.sh     = {write_in, addr_in};
					d.mosi   = write_in;
					d.sel_n  = 1'b0;
					d.first  = 1'b1;
					d.bitcnt = rtcsp_pkg::BIT_FIRST;
					d.tmr    = rtcsp_pkg::TMR_ZERO;
					d.state  = rtcsp_pkg::MST_LEAD;
				end
			end
			rtcsp_pkg::MST_LEAD: begin
				d.tmr = q.tmr + rtcsp_pkg::TMR_STEP;
				if (q.tmr == rtcsp_pkg::SEL_LEAD_CYC - rtcsp_pkg::TMR_STEP) begin
					d.tmr   = rtcsp_pkg::TMR_ZERO;
					d.state = rtcsp_pkg::MST_SHIFT;
				end
			end
			// mode zero: rise in the middle of each bit, miso taken before the fall
			rtcsp_pkg::MST_SHIFT: begin
				d.tmr = q.tmr + rtcsp_pkg::TMR_STEP;
				if (q.tmr == rtcsp_pkg::SCLK_HALF_CYC - rtcsp_pkg::TMR_STEP) begin
					d.tmr  = rtcsp_pkg::TMR_ZERO;
					d.sclk = !q.sclk;
					if (q.sclk) begin
						d.rx     = rx_next;
						d.bitcnt = q.bitcnt + rtcsp_pkg::BIT_STEP;
						if (q.bitcnt != rtcsp_pkg::BIT_LAST) begin
							d.sh   = {q.sh[rtcsp_pkg::DATA_W-2:0], 1'b0};
							d.mosi = q.sh[rtcsp_pkg::DATA_W-2];
						end else begin
							if (!q.first && q.wr != rtcsp_pkg::DIR_WRITE) begin
								d.rdata  = rx_next;
								d.rvalid = 1'b1;
							end
							d.first = 1'b0;
							if (q.left == rtcsp_pkg::LEFT_NONE) begin
								d.state = rtcsp_pkg::MST_LAG;
							end else begin
								d.left = q.left - rtcsp_pkg::LEFT_STEP;
								d.sh   = q.wr ? wdata_in : rtcsp_pkg::BYTE_ZERO;
								d.mosi = q.wr ? wdata_in[rtcsp_pkg::DATA_W-1] : 1'b0;
								d.take = q.wr;
							end
						end
					end
				end
			end
			rtcsp_pkg::MST_LAG: begin
				d.tmr = q.tmr + rtcsp_pkg::TMR_STEP;
				if (q.tmr == rtcsp_pkg::SEL_LAG_CYC - rtcsp_pkg::TMR_STEP) begin
					d.tmr   = rtcsp_pkg::TMR_ZERO;
					d.sel_n = 1'b1;
					d.state = rtcsp_pkg::MST_GAP;
				end
			end
			default: begin
				d.state = rtcsp_pkg::MST_GAP;
			end
		endcase

		d.busy = (d.state != rtcsp_pkg::MST_IDLE);
	end

	// ==========================================================
	// state register; comes out of reset deselected and in the gap
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q       <= '0;
			q.state <= rtcsp_pkg::MST_GAP;
			q.sel_n <= 1'b1;
			q.busy  <= 1'b1;
		end else if (ce_in) begin
			q <= d;
		end
	end

	assign bus.sclk        = q.sclk;
	assign bus.sel_n       = q.sel_n;
	assign bus.mosi        = q.mosi;
	assign wdata_take_out  = q.take;
	assign rdata_out       = q.rdata;
	assign rdata_valid_out = q.rvalid;
	assign busy_out        = q.busy;
	assign dev_reset_out   = q.dev_rst;
endmodule

// [rtcsp_chk_sva.sv]
// concurrent checks on the master-to-rtc link and the rtc port side outputs
module rtcsp_chk #(
	parameter logic [rtcsp_pkg::RCNT_W-1:0] RECOVERY_HOLD_CYC = rtcsp_pkg::RECOVERY_HOLD_CYC_DEFAULT
) (
	input  wire logic                         clk_in,
	input  wire logic                         srst_in,
	input  wire logic                         sclk,
	input  wire logic                         sel_n,
	input  wire logic                         mosi,
	input  wire logic                         miso_drv,
	input  wire logic                         miso_oe,
	input  wire logic                         rst_n_oe,
	input  wire logic                         rst_n,
	input  wire logic                         power_fail_trip_in,
	input  wire logic                         battery_switch_level_in,
	input  wire logic                         mem_we_out,
	input  wire logic [rtcsp_pkg::ADDR_W-1:0] mem_addr_out,
	input  wire logic                         divider_reset_out,
	input  wire logic                         clock_hold_out,
	input  wire logic                         reset_active_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// helper state: rises per frame, first bit, low-half age, supply-good run
	logic        sclk_q;
	logic        dir_q;
	logic [4:0]  rise_q;
	logic [3:0]  low_q;
	logic [23:0] pf_low_q;

	// pin edges are seen here on the system clock from the raw pins, two cycles before the port's synced copies show them
	always_ff @(posedge clk_in) begin
		sclk_q <= sclk;
		low_q  <= sclk ? 4'h0 : ((low_q == 4'hF) ? low_q : low_q + 4'h1);
		if (srst_in || power_fail_trip_in) begin
			pf_low_q <= 24'h000000;
		end else if (!(&pf_low_q)) begin
			pf_low_q <= pf_low_q + 24'h000001;
		end
		if (srst_in || sel_n) begin
			rise_q <= 5'h00;
		end else if (sclk && !sclk_q && rise_q != 5'h1F) begin
			rise_q <= rise_q + 5'h01;
			if (rise_q == 5'h00) begin
				dir_q <= mosi;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// ==========================================================
	// link behaviour
	property p_desel_float; sel_n [*5] |-> !miso_oe; endproperty
	a_desel_float: assert property (p_desel_float) else $error("output driven while deselected");
	property p_out_on_low;
		miso_oe && $past(miso_oe) && $changed(miso_drv) |-> !sel_n && low_q inside {[4'h2:4'h5]};
	endproperty
	a_out_on_low: assert property (p_out_on_low) else $error("output moved off its slot");
	property p_oe_after_cmd; $rose(miso_oe) |-> rise_q == 5'h08 && !dir_q && !sel_n; endproperty
	a_oe_after_cmd: assert property (p_oe_after_cmd) else $error("output enabled early");
	property p_write_quiet; !sel_n && dir_q && rise_q != 5'h00 |-> !miso_oe; endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("output driven in a write");
	property p_hold_desel; sel_n [*6] |-> !clock_hold_out; endproperty
	a_hold_desel: assert property (p_hold_desel) else $error("clock hold kept after deselect");
	property p_div_reset;
		mem_we_out || divider_reset_out |->
			mem_we_out && (divider_reset_out == (mem_addr_out < 6'h08));
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("divider reset wrong");

	// ==========================================================
	// supply loss behaviour
	property p_fail_quiet;
		power_fail_trip_in [*5] |-> !miso_oe && !mem_we_out && reset_active_out;
	endproperty
	a_fail_quiet: assert property (p_fail_quiet) else $error("port active in power fail");
	property p_fail_onset;
		$rose(power_fail_trip_in) && !battery_switch_level_in |-> ##[1:6] !rst_n;
	endproperty
	a_fail_onset: assert property (p_fail_onset) else $error("reset pin late");
	property p_fail_reset;
		(reset_active_out && !battery_switch_level_in) [*4] |-> rst_n_oe && !rst_n;
	endproperty
	a_fail_reset: assert property (p_fail_reset) else $error("reset pin released early");
	property p_recover_hold; $fell(reset_active_out) |-> pf_low_q >= RECOVERY_HOLD_CYC; endproperty
	a_recover_hold: assert property (p_recover_hold) else $error("recovery hold too short");
	property p_battery_float; battery_switch_level_in [*4] |-> !miso_oe && !rst_n_oe; endproperty
	a_battery_float: assert property (p_battery_float) else $error("pin driven on battery");
endmodule

// [tb.sv]
// self-checking bench: master and rtc port on one link, a bit-banged second link
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// stimulus, design outputs and bench state
	localparam logic [23:0] REC_CYC = 24'h000010; // short hold keeps the run brief
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        start_in = 1'b0;
	logic        write_in = 1'b0;
	logic [6:0]  addr_in = 7'h00;
	logic [6:0]  count_in = 7'h00;
	logic [7:0]  wdata_in = 8'h00;
	logic        power_fail_trip = 1'b0;
	logic        battery_switch_level = 1'b0;
	logic        take, rvalid, busy, devrst, we1, hold1, div1, ract1, we2;
	logic [7:0]  rdata, wd1, wd2;
	logic [5:0]  addr1, addr2;
	logic [7:0]  mem1 [64], exp1 [64], mem2 [64], exp2 [64], wbuf [128], tx2 [4], rx2 [4];
	logic [7:0]  rq [$];
	int          widx = 0, wr2 = 0, cycles = 0, bad_count = 0, checks = 0;

	rtcsp_if bus_if ();
	rtcsp_if bus2 ();
	rtcsp_master rtcsp_master_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .bus(bus_if),
		.start_in(start_in), .write_in(write_in), .addr_in(addr_in), .count_in(count_in),
		.wdata_in(wdata_in), .wdata_take_out(take), .rdata_out(rdata), .rdata_valid_out(rvalid),
		.busy_out(busy), .dev_reset_out(devrst));
	rtcsp_device #(.RECOVERY_HOLD_CYC(REC_CYC)) rtcsp_device_i (.clk_in(clk_in), .srst_in(srst_in),
		.ce_in(1'b1), .bus(bus_if), .power_fail_trip_in(power_fail_trip),
		.battery_switch_level_in(battery_switch_level), .mem_rdata_in(mem1[addr1]),
		.mem_addr_out(addr1), .mem_wdata_out(wd1), .mem_we_out(we1), .clock_hold_out(hold1),
		.divider_reset_out(div1), .reset_active_out(ract1));
	rtcsp_device #(.RECOVERY_HOLD_CYC(REC_CYC)) rtcsp_device_i2 (.clk_in(clk_in), .srst_in(srst_in),
		.ce_in(1'b1), .bus(bus2), .power_fail_trip_in(power_fail_trip),
		.battery_switch_level_in(battery_switch_level), .mem_rdata_in(mem2[addr2]),
		.mem_addr_out(addr2), .mem_wdata_out(wd2), .mem_we_out(we2), .clock_hold_out(),
		.divider_reset_out(), .reset_active_out());
	rtcsp_chk #(.RECOVERY_HOLD_CYC(REC_CYC)) rtcsp_chk_i (.clk_in(clk_in), .srst_in(srst_in),
		.sclk(bus_if.sclk), .sel_n(bus_if.sel_n), .mosi(bus_if.mosi), .miso_drv(bus_if.miso_drv),
		.miso_oe(bus_if.miso_oe), .rst_n_oe(bus_if.rst_n_oe), .rst_n(bus_if.rst_n),
		.power_fail_trip_in(power_fail_trip), .battery_switch_level_in(battery_switch_level),
		.mem_we_out(we1), .mem_addr_out(addr1), .divider_reset_out(div1), .clock_hold_out(hold1),
		.reset_active_out(ract1));

	always #25 clk_in = ~clk_in;

	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// pointer wraps inside 64 places, address bit six never counts
	function automatic logic [5:0] slot(input logic [6:0] a, input int k);
		return a[5:0] + 6'(k);
	endfunction

	// memories behind both ports, master write feed, read capture, hang guard
	always @(posedge clk_in) begin
		if (we1 === 1'b1) mem1[addr1] <= wd1;
		if (we2 === 1'b1) mem2[addr2] <= wd2;
		if (we2 === 1'b1) wr2++;
		if (rvalid === 1'b1) rq.push_back(rdata);
		if (take === 1'b1) widx <= widx + 1;
		wdata_in <= wbuf[(take === 1'b1) ? widx + 1 : widx];
		if (we1 === 1'b1 && addr1 < 6'h07) check("hold clock byte", 8'h01, {7'h00, hold1});
		if (we1 === 1'b1 && addr1 > 6'h08 && addr1 < 6'h3F)
			check("hold ram byte", 8'h00, {7'h00, hold1});
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			wrap_up();
		end
	end

	// one master frame; waits are bounded, a stuck master ends in the hang guard
	task automatic frame(input logic w, input logic [6:0] a, input int n);
		int lim;
		lim = 0;
		widx = 0;
		do @(negedge clk_in); while (busy !== 1'b0 && ++lim < 5000);
		@(posedge clk_in);
		start_in <= 1'b1;
		write_in <= w;
		addr_in <= a;
		count_in <= 7'(n);
		@(posedge clk_in);
		start_in <= 1'b0;
		lim = 0;
		do @(negedge clk_in); while (busy !== 1'b0 && ++lim < 800 * (n + 2));
	endtask

	task automatic write_burst(input logic [6:0] a, input int n);
		for (int k = 0; k < n; k++) begin
			wbuf[k] = 8'($urandom);
			exp1[slot(a, k)] = wbuf[k];
		end
		frame(1'b1, a, n);
	endtask

	task automatic read_check(input logic [6:0] a, input int n);
		rq.delete();
		frame(1'b0, a, n);
		check("read count", 8'(n), 8'(rq.size()));
		for (int k = 0; k < n && k < rq.size(); k++)
			check("read byte", exp1[slot(a, k)], rq[k]);
	endtask

	// second link: bench as master, data set while clock low, sampled late in high half
	task automatic bit2(input logic b, output logic r);
		@(posedge clk_in);
		bus2.sclk <= 1'b0;
		bus2.mosi <= b;
		repeat (5) @(posedge clk_in);
		bus2.sclk <= 1'b1;
		repeat (4) @(posedge clk_in);
		r = bus2.miso;
	endtask

	task automatic frame2(input logic m3, input int nbits);
		logic r;
		@(posedge clk_in);
		bus2.sclk <= m3;
		repeat (5) @(posedge clk_in);
		bus2.sel_n <= 1'b0;
		repeat (5) @(posedge clk_in);
		for (int i = 0; i < nbits; i++) begin
			bit2(tx2[i / 8][7 - i % 8], r);
			rx2[i / 8][7 - i % 8] = r;
		end
		@(posedge clk_in);
		bus2.sclk <= m3;
		repeat (5) @(posedge clk_in);
		bus2.sel_n <= 1'b1;
		bus2.mosi <= ~bus2.mosi; // released line must not keep its last level
		repeat (8) @(posedge clk_in);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		bus2.sclk = 1'b0;
		bus2.sel_n = 1'b0; // select already low at reset: no fall is seen
		bus2.mosi = 1'b0;
		void'($urandom(65));
		for (int i = 0; i < 64; i++) begin
			mem1[i] = 8'($urandom);
			exp1[i] = mem1[i];
			mem2[i] = 8'($urandom);
			exp2[i] = mem2[i];
			wbuf[i] = 8'h00;
			wbuf[i + 64] = 8'h00;
		end
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		tx2[0] = 8'h90;
		tx2[1] = 8'h5A;
		frame2(1'b0, 16);
		frame2(1'b0, 13);
		check("writes after bad frames", 8'h00, 8'(wr2));
		check("idle output", 8'h01, {7'h00, bus2.miso});
		tx2[0] = 8'hBF;
		tx2[1] = 8'($urandom);
		tx2[2] = 8'($urandom);
		exp2[6'h3F] = tx2[1];
		exp2[6'h00] = tx2[2];
		frame2(1'b1, 24);
		tx2[0] = 8'h3F;
		frame2(1'b1, 24);
		check("mode three first", exp2[6'h3F], rx2[1]);
		check("mode three second", exp2[6'h00], rx2[2]);
		$display("test second link done");
		write_burst(7'h3E, 4);
		write_burst(7'h46, 3);
		for (int t = 0; t < 6; t++) write_burst(7'($urandom), 1 + $urandom % 8);
		read_check(7'h00, 64);
		read_check(7'h7D, 5);
		$display("test bursts done");
		for (int k = 0; k < 4; k++) wbuf[k] = ~exp1[slot(7'h20, k)];
		fork
			frame(1'b1, 7'h20, 4);
			begin
				repeat (30) @(posedge clk_in);
				power_fail_trip <= 1'b1;
			end
		join
		check("reset pin in fail", 8'h00, {7'h00, bus_if.rst_n});
		check("master reset view", 8'h01, {7'h00, devrst});
		@(posedge clk_in);
		battery_switch_level <= 1'b1;
		repeat (6) @(posedge clk_in);
		check("battery enables", 8'h00, {6'h00, bus_if.miso_oe, bus_if.rst_n_oe});
		battery_switch_level <= 1'b0;
		repeat (6) @(posedge clk_in);
		fork
			frame(1'b1, 7'h21, 3);
			begin
				@(posedge clk_in);
				power_fail_trip <= 1'b0;
			end
		join
		check("reset pin after recovery", 8'h01, {7'h00, bus_if.rst_n});
		read_check(7'h20, 4);
		$display("test power loss done");
		wrap_up();
	end
endmodule
